// ### rtl/isr_status_bank.v
// status reporting register bank: standard event and operation status groups
`include "isr_consts.vh"
`default_nettype none
module isr_status_bank (
  input wire CLK_SYS_I,
  input wire RST_N_I,
  // register access port, one access per strobe
  input wire [`ISR_SEL_W-1:0] REG_SEL_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [15:0] REG_WDATA_I,
  output reg [15:0] REG_RDATA_O,
  output reg REG_RVALID_O,
  // commands from the command parser
  input wire CLS_I,
  input wire OPC_DONE_I,
  input wire SUPPRESS_I,
  input wire RESUME_I,
  // error logging: number of a newly logged error
  input wire ERR_LOG_I,
  input wire signed [15:0] ERR_NUM_I,
  input wire LOCAL_KEY_I,
  // live instrument state
  input wire IQ_PRESENT_I,
  input wire BERT_OPTION_I,
  input wire IQ_CAL_I,
  input wire SETTLING_I,
  input wire SWEEPING_I,
  input wire BERT_RUN_I,
  input wire WAIT_TRIG_I,
  // summaries for the status byte
  output reg ESB_SUMMARY_O,
  output reg OPER_SUMMARY_O
);

reg [7:0] sev_reg;
reg [7:0] sev_next;
reg [7:0] sen_reg;
reg [15:0] ocon_reg;
reg [15:0] ocon_prev_reg;
reg [15:0] nflt_reg;
reg [15:0] pflt_reg;
reg [15:0] oev_reg;
wire [15:0] oev_next;
reg [15:0] oen_reg;
reg supp_reg;
reg [15:0] ocon_next;
wire [15:0] trans;

wire rd_sev = REG_RD_I && (REG_SEL_I == `ISR_SEL_SEV);
wire rd_oev = REG_RD_I && (REG_SEL_I == `ISR_SEL_OEV);

// error class decode on the logged number
wire err_q = ERR_LOG_I && ERR_NUM_I >= `ISR_QERR_LO && ERR_NUM_I <= `ISR_QERR_HI;
wire err_d = ERR_LOG_I && ((ERR_NUM_I >= `ISR_DERR_LO && ERR_NUM_I <= `ISR_DERR_HI) ||
  (ERR_NUM_I >= `ISR_DERR_PLO && ERR_NUM_I <= `ISR_DERR_PHI));
wire err_x = ERR_LOG_I && ERR_NUM_I >= `ISR_XERR_LO && ERR_NUM_I <= `ISR_XERR_HI;
wire err_c = ERR_LOG_I && ERR_NUM_I >= `ISR_CERR_LO && ERR_NUM_I <= `ISR_CERR_HI;

always @* begin
  sev_next = sev_reg;
  // clearing by read or clear-status loses to a new event in the same cycle
  if (rd_sev || CLS_I) begin
    sev_next = `ISR_RST8;
  end
  if (OPC_DONE_I) begin
    sev_next[`ISR_SEV_DONE] = 1'b1;
  end
  if (err_q) begin
    sev_next[`ISR_SEV_QERR] = 1'b1;
  end
  if (err_d) begin
    sev_next[`ISR_SEV_DERR] = 1'b1;
  end
  if (err_x) begin
    sev_next[`ISR_SEV_XERR] = 1'b1;
  end
  if (err_c) begin
    sev_next[`ISR_SEV_CERR] = 1'b1;
  end
  if (LOCAL_KEY_I) begin
    sev_next[`ISR_SEV_LKEY] = 1'b1;
  end
  sev_next[`ISR_SEV_CTRL] = 1'b0;
end

always @* begin
  ocon_next = `ISR_RST16;
  ocon_next[`ISR_OC_IQCAL] = IQ_CAL_I & IQ_PRESENT_I;
  ocon_next[`ISR_OC_SETTLE] = SETTLING_I;
  ocon_next[`ISR_OC_SWEEP] = SWEEPING_I;
  ocon_next[`ISR_OC_MEAS] = BERT_RUN_I & BERT_OPTION_I;
  ocon_next[`ISR_OC_WTRIG] = WAIT_TRIG_I;
  // remaining bits stay zero
end

// per-bit transition detect and latch; a set beats a clear in one cycle
genvar gi;
generate
  for (gi = 0; gi < 16; gi = gi + 1) begin : g_trans
    assign trans[gi] = (pflt_reg[gi] & ~ocon_prev_reg[gi] & ocon_reg[gi]) |
      (nflt_reg[gi] & ocon_prev_reg[gi] & ~ocon_reg[gi]);
    assign oev_next[gi] = (trans[gi] & ~supp_reg) | (oev_reg[gi] & ~(rd_oev | CLS_I));
  end
endgenerate

always @(posedge CLK_SYS_I) begin
  if (!RST_N_I) begin
    // power-on reset is the power cycle
    sev_reg <= `ISR_SEV_PWR_RST;
    sen_reg <= `ISR_RST8;
    ocon_reg <= `ISR_RST16;
    ocon_prev_reg <= `ISR_RST16;
    nflt_reg <= `ISR_RST16;
    pflt_reg <= `ISR_PFLT_RST;
    oev_reg <= `ISR_RST16;
    oen_reg <= `ISR_RST16;
    supp_reg <= 1'b0;
    REG_RDATA_O <= `ISR_RST16;
    REG_RVALID_O <= 1'b0;
    ESB_SUMMARY_O <= 1'b0;
    OPER_SUMMARY_O <= 1'b0;
  end else begin
    sev_reg <= sev_next;
    oev_reg <= oev_next;
    if (SUPPRESS_I) begin
      supp_reg <= 1'b1;
    end else if (RESUME_I) begin
      supp_reg <= 1'b0;
    end
    // suppressed group is frozen, saving the maintenance work
    if (!supp_reg) begin
      ocon_reg <= ocon_next;
      ocon_prev_reg <= ocon_reg;
    end
    if (REG_WR_I) begin
      case (REG_SEL_I)
        `ISR_SEL_SEN: sen_reg <= REG_WDATA_I[7:0];
        `ISR_SEL_NFLT: nflt_reg <= REG_WDATA_I;
        `ISR_SEL_PFLT: pflt_reg <= REG_WDATA_I;
        `ISR_SEL_OEN: oen_reg <= REG_WDATA_I;
        // condition, event status and operation event ignore writes
        default: sen_reg <= sen_reg;
      endcase
    end
    REG_RVALID_O <= REG_RD_I;
    if (REG_RD_I) begin
      case (REG_SEL_I)
        `ISR_SEL_SEV: REG_RDATA_O <= {`ISR_HI_PAD, sev_reg};
        `ISR_SEL_SEN: REG_RDATA_O <= {`ISR_HI_PAD, sen_reg};
        `ISR_SEL_OCON: REG_RDATA_O <= ocon_reg;
        `ISR_SEL_NFLT: REG_RDATA_O <= nflt_reg;
        `ISR_SEL_PFLT: REG_RDATA_O <= pflt_reg;
        `ISR_SEL_OEV: REG_RDATA_O <= oev_reg;
        `ISR_SEL_OEN: REG_RDATA_O <= oen_reg;
        default: REG_RDATA_O <= `ISR_RST16;
      endcase
    end
    // computed from next event values so the summary follows an event within one edge, an enable write one edge later
    ESB_SUMMARY_O <= |(sev_next & sen_reg);
    OPER_SUMMARY_O <= |(oev_next & oen_reg);
  end
end

endmodule // isr_status_bank
`default_nettype wire

// ### common/isr_consts.vh
// constants for the instrument status reporting register bank
`ifndef ISR_CONSTS_VH
`define ISR_CONSTS_VH
// register select codes on the access port
`define ISR_SEL_W 3
`define ISR_SEL_SEV 3'h0
`define ISR_SEL_SEN 3'h1
`define ISR_SEL_OCON 3'h2
`define ISR_SEL_NFLT 3'h3
`define ISR_SEL_PFLT 3'h4
`define ISR_SEL_OEV 3'h5
`define ISR_SEL_OEN 3'h6
// event status bit positions
`define ISR_SEV_DONE 0
`define ISR_SEV_CTRL 1
`define ISR_SEV_QERR 2
`define ISR_SEV_DERR 3
`define ISR_SEV_XERR 4
`define ISR_SEV_CERR 5
`define ISR_SEV_LKEY 6
`define ISR_SEV_PWR 7
// operation condition bit positions
`define ISR_OC_IQCAL 0
`define ISR_OC_SETTLE 1
`define ISR_OC_SWEEP 3
`define ISR_OC_MEAS 4
`define ISR_OC_WTRIG 5
// error number class bounds
`define ISR_QERR_LO (-16'sd499)
`define ISR_QERR_HI (-16'sd400)
`define ISR_DERR_LO (-16'sd399)
`define ISR_DERR_HI (-16'sd300)
`define ISR_DERR_PLO 16'sd1
`define ISR_DERR_PHI 16'sd32767
`define ISR_XERR_LO (-16'sd299)
`define ISR_XERR_HI (-16'sd200)
`define ISR_CERR_LO (-16'sd199)
`define ISR_CERR_HI (-16'sd100)
// reset values
`define ISR_RST8 8'h00
`define ISR_RST16 16'h0000
`define ISR_PFLT_RST 16'h7FFF
`define ISR_SEV_PWR_RST 8'h80
// upper byte of an 8-bit register on the 16-bit read path
`define ISR_HI_PAD 8'h00
`endif

// ### test/isr_status_bank_props.sv
// assertions on the ports of the status reporting bank
`default_nettype none
module isr_status_bank_props (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic [2:0] REG_SEL_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic OPC_DONE_I,
  input wire logic LOCAL_KEY_I,
  input wire logic ESB_SUMMARY_O,
  input wire logic OPER_SUMMARY_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read not answered");
  a_answer_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("answer without read");
  a_rdata_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved");
  a_rqc_zero: assert property (REG_RD_I && REG_SEL_I == 3'h0 |=> REG_RDATA_O[15:8] == 8'h00 && !REG_RDATA_O[1])
    else $error("event status bit 1 set");
  a_cond_unused: assert property (REG_RD_I && REG_SEL_I == 3'h2 |=> REG_RDATA_O[15:6] == 10'h000 && !REG_RDATA_O[2])
    else $error("unused condition bit set");
  // the bench spaces a pulse and the next read by two edges
  a_opc_sets: assert property (OPC_DONE_I ##2 (REG_RD_I && REG_SEL_I == 3'h0) |=> REG_RDATA_O[0])
    else $error("completion bit lost");
  a_key_sets: assert property (LOCAL_KEY_I ##2 (REG_RD_I && REG_SEL_I == 3'h0) |=> REG_RDATA_O[6])
    else $error("local key bit lost");
  a_esb_masked: assert property (REG_WR_I && REG_SEL_I == 3'h1 && REG_WDATA_I[7:0] == 8'h00 |-> ##[1:2] !ESB_SUMMARY_O)
    else $error("event summary not masked");
  a_oper_masked: assert property (REG_WR_I && REG_SEL_I == 3'h6 && REG_WDATA_I == 16'h0000 |-> ##[1:2] !OPER_SUMMARY_O)
    else $error("operation summary not masked");
  c_esb: cover property (ESB_SUMMARY_O);
  c_oper: cover property (OPER_SUMMARY_O);
  c_unmapped: cover property (REG_RD_I && REG_SEL_I == 3'h7);
endmodule // isr_status_bank_props
bind isr_status_bank isr_status_bank_props u_props (.CLK_SYS_I, .RST_N_I, .REG_SEL_I, .REG_WR_I, .REG_RD_I,
  .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .OPC_DONE_I, .LOCAL_KEY_I, .ESB_SUMMARY_O, .OPER_SUMMARY_O);
`default_nettype wire

// ### test/isr_status_bank_tb.sv
// self-checking bench for the status reporting bank
`default_nettype none
module isr_status_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, esb, oper, rvld;
  logic [2:0] sel = 0;
  logic [15:0] wd = 0, rdat;
  logic [5:0] ev = 0;
  logic [4:0] lv = 0;
  logic [1:0] opt = 2'h3;
  logic signed [15:0] en = 0;
  int errors = 0;
  int total_checks = 0;
  isr_status_bank u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_SEL_I(sel), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .REG_RVALID_O(rvld), .CLS_I(ev[0]), .OPC_DONE_I(ev[1]),
    .ERR_LOG_I(ev[2]), .LOCAL_KEY_I(ev[3]), .SUPPRESS_I(ev[4]), .RESUME_I(ev[5]), .ERR_NUM_I(en),
    .IQ_PRESENT_I(opt[1]), .BERT_OPTION_I(opt[0]), .IQ_CAL_I(lv[0]), .SETTLING_I(lv[1]), .SWEEPING_I(lv[2]),
    .BERT_RUN_I(lv[3]), .WAIT_TRIG_I(lv[4]), .ESB_SUMMARY_O(esb), .OPER_SUMMARY_O(oper));
  initial forever #25 clk = ~clk;
  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  // strobes drop a full cycle before the next access starts
  task automatic acc(input logic [2:0] s, input logic w, input logic [15:0] d);
    @(negedge clk);
    {sel, wr, rd, wd} = {s, w, !w, d};
    @(negedge clk);
    {wr, rd} = 2'h0;
  endtask
  task automatic rdc(input logic [2:0] s, input logic [15:0] exp);
    acc(s, 0, 0);
    chk(rvld, 16'h0001);
    chk(rdat, exp);
  endtask
  task automatic pul(input logic [5:0] p);
    @(negedge clk);
    ev = p;
    @(negedge clk);
    ev = 0;
  endtask
  task automatic t_errors;
    int n[5] = '{-499, -300, 32767, -200, -100};
    rdc(3'h0, 16'h0080);
    rdc(3'h4, 16'h7FFF);
    rdc(3'h7, 16'h0000);
    en = -500;
    pul(6'h04);
    en = 0;
    pul(6'h04);
    rdc(3'h0, 16'h0000);
    foreach (n[i]) begin
      en = 16'(n[i]);
      pul(6'h04);
    end
    pul(6'h0A);
    rdc(3'h0, 16'h007D);
  endtask
  task automatic t_enable;
    acc(3'h1, 1, 16'h01A0);
    rdc(3'h1, 16'h00A0);
    en = -250;
    pul(6'h04);
    chk(esb, 0);
    en = -150;
    pul(6'h04);
    chk(esb, 1);
    pul(6'h01);
    @(negedge clk);
    chk(esb, 0);
    acc(3'h1, 1, 0);
  endtask
  task automatic t_oper;
    lv = 5'h1F;
    repeat (3) @(negedge clk);
    rdc(3'h2, 16'h003B);
    acc(3'h2, 1, 16'hFFFF);
    opt = 0;
    repeat (3) @(negedge clk);
    rdc(3'h2, 16'h002A);
    rdc(3'h5, 16'h003B);
    rdc(3'h5, 16'h0000);
    acc(3'h3, 1, 16'h0008);
    acc(3'h4, 1, 16'h0000);
    acc(3'h6, 1, 16'h0008);
    lv = 5'h1B;
    repeat (3) @(negedge clk);
    chk(oper, 1);
    rdc(3'h5, 16'h0008);
    lv = 5'h1F;
    repeat (3) @(negedge clk);
    chk(oper, 0);
    acc(3'h6, 1, 0);
    pul(6'h10);
    lv = 0;
    repeat (3) @(negedge clk);
    rdc(3'h2, 16'h002A);
    pul(6'h20);
    repeat (3) @(negedge clk);
    rdc(3'h2, 16'h0000);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    t_errors();
    t_enable();
    t_oper();
    conclude();
  end
  // the tests need about 90 cycles
  initial begin
    #50000;
    errors++;
    conclude();
  end
endmodule // isr_status_bank_tb
`default_nettype wire
